// File: logic/tcg_glue.sv
// glue logic of the trunking card: resets, clock, decode, latches, serial routing
`timescale 1ns/10ps
// Functional notes
// - watchdog resets after two unserviced seconds
// - reset pulse on flash entry and exit
// - flash status high during flash loading
// - modem reset input resets cpu, modem, latches
// - buffer external 11.0592 MHz clock outward
// - latch low address byte on ale
// - program memory selected only by store strobe
// - decode a13..a11 qualified by read/write
// - ram and modem address ranges mapped
// - switch banks readable at three addresses
// - writes hit latches, reads hit switches
// - transceiver turned toward cpu on switch and phone modem reads
// - buffered inputs on port, no handshake
// - indicator latch drives seven indicators
// - data present from second latch
// - tone code bit from third latch
// - async pair routed by select and flash
// - async channel both directions, 19.2 kbaud
// - phone modem deserialises, bytes on read
// - phone modem latches written transmit bytes
module tcg_glue
   import tcg_pkg::*;
#(
   parameter longint WDOG_CYCLES = WDOG_CYCLES_L  // shorten for simulation
) (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        reference_clock,
   output logic             modem_clk_out,
   output logic             cpu_clk_out,
   input  wire logic [7:0]  port0_in,
   output logic      [7:0]  port0_out,
   output logic             port0_oe,
   input  wire logic [7:0]  addr_hi,
   input  wire logic        ale,
   input  wire logic        program_store_strobe_b,
   input  wire logic        rd_b,
   input  wire logic        wr_b,
   output logic      [7:0]  addr_lo,
   output logic             prog_mem_sel,
   output logic             ram_ce,
   output logic             rf_modem_ce,
   output logic             phone_modem_ce,
   input  wire logic        watchdog_service,
   input  wire logic        modem_reset_in,
   input  wire logic        flash_vpp,
   output logic             flash_mode_active,
   output logic             cpu_reset,
   output logic             phone_modem_reset,
   input  wire logic [7:0]  switch_one,
   input  wire logic [7:0]  switch_two,
   input  wire logic [7:0]  switch_three,
   input  wire logic [7:0]  ext_inputs,
   output logic      [7:0]  cpu_input_port,
   output logic      [6:0]  indicators,
   output logic             data_present_out,
   output logic             tone_code_bit,
   input  wire logic        site_link_select_one,
   input  wire logic        site_link_select_two,
   input  wire logic        jumper_route_select,
   input  wire logic        cpu_txd,
   output logic             cpu_rxd,
   input  wire logic        backup_serial_link_rx,
   output logic             backup_serial_link_tx,
   input  wire logic        flash_rx,
   output logic             flash_tx,
   input  wire logic        site_one_rx,
   output logic             site_one_tx,
   input  wire logic        site_two_rx,
   output logic             site_two_tx,
   input  wire logic        sync_receive_clock,
   input  wire logic        sync_receive_serial_in,
   input  wire logic        sync_transmit_clock,
   output logic             sync_transmit_serial_out,
   output logic             sync_receive_overrun
);

   ////////////////////////////////////////////////////////////////////////////
   // input synchronisers

   logic [NSYNC-1:0] async_in;   // raw pins
   logic [NSYNC-1:0] sy_a;       // first stage, read only by sy_b
   logic [NSYNC-1:0] sy_b;       // second stage
   logic [NSYNC-1:0] sy_c;       // third stage
   logic [NSYNC-1:0] sy;         // filtered level
   logic [NSYNC-1:0] sy_q;       // previous filtered level

   assign async_in = {jumper_route_select, site_link_select_two, site_link_select_one,
                      sync_transmit_clock, sync_receive_serial_in, sync_receive_clock,
                      flash_vpp, modem_reset_in, watchdog_service, wr_b, rd_b,
                      program_store_strobe_b, ale};

   // three flops per pin; a change counts once the last two agree
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
               // start at the pin's idle level, so release gives no false strobe edge
               sy_a[gi] <= SYNC_IDLE[gi];
               sy_b[gi] <= SYNC_IDLE[gi];
               sy_c[gi] <= SYNC_IDLE[gi];
               sy[gi]   <= SYNC_IDLE[gi];
               sy_q[gi] <= SYNC_IDLE[gi];
            end else begin
               sy_a[gi] <= async_in[gi];
               sy_b[gi] <= sy_a[gi];
               sy_c[gi] <= sy_b[gi];
               if (sy_b[gi] == sy_c[gi]) begin
                  sy[gi] <= sy_c[gi];
               end
               sy_q[gi] <= sy[gi];
            end
         end
      end
   endgenerate

   // edge helpers on filtered levels
   wire ale_rise  = sy[S_ALE] & ~sy_q[S_ALE];
   wire rd_fall   = ~sy[S_RD_B] & sy_q[S_RD_B];
   wire wr_rise   = sy[S_WR_B] & ~sy_q[S_WR_B];
   wire wdog_rise = sy[S_WDOG] & ~sy_q[S_WDOG];
   wire flash_chg = sy[S_FVPP] ^ sy_q[S_FVPP];
   wire rxclk_rise = sy[S_RXCLK] & ~sy_q[S_RXCLK];
   wire txclk_fall = ~sy[S_TXCLK] & sy_q[S_TXCLK];

   ////////////////////////////////////////////////////////////////////////////
   // clock distribution

   // external reference passed straight to both outputs
   // no local oscillator; a clock is not retimed, so these are plain wires
   assign modem_clk_out = reference_clock;
   assign cpu_clk_out   = reference_clock;

   ////////////////////////////////////////////////////////////////////////////
   // reset generation

   tcg_rst_state_t rst_st;        // reset generator state
   logic [15:0]    rst_cnt;       // pulse width counter
   logic [31:0]    wdog_cnt;      // cycles since last service
   logic           wdog_fire;     // watchdog expiry
   logic           sys_reset;     // combined reset to cpu, modem, latches

   // expiry after two seconds without a service
   assign wdog_fire = (wdog_cnt == 32'(WDOG_CYCLES - 1));

   // watchdog counter, restarted by each service and by any reset
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wdog_cnt <= 32'h0;
      end else if (wdog_rise || sys_reset || wdog_fire) begin
         wdog_cnt <= 32'h0;
      end else begin
         wdog_cnt <= wdog_cnt + 32'h1;
      end
   end

   // pulse generator; a new trigger mid-pulse restarts the width
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_st  <= RST_IDLE;
         rst_cnt <= 16'h0;
      end else begin
         case (rst_st)
            RST_IDLE: begin
               // flash entry or exit both start a pulse
               if (flash_chg || wdog_fire) begin
                  rst_st  <= RST_PULSE;
                  rst_cnt <= 16'h0;
               end
            end
            RST_PULSE: begin
               if (flash_chg || wdog_fire) begin
                  rst_cnt <= 16'h0;
               end else if (rst_cnt == RST_PULSE_LAST) begin
                  rst_st <= RST_IDLE;
               end else begin
                  rst_cnt <= rst_cnt + 16'h1;
               end
            end
            default: begin
               rst_st <= RST_IDLE;
            end
         endcase
      end
   end

   // modem reset input joins the generated pulse for every target
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sys_reset <= 1'b1;
      end else begin
         sys_reset <= (rst_st == RST_PULSE) | sy[S_MRST];
      end
   end

   assign cpu_reset         = sys_reset;
   assign phone_modem_reset = sys_reset;

   // status follows the filtered programming voltage level
   assign flash_mode_active = sy[S_FVPP];

   ////////////////////////////////////////////////////////////////////////////
   // bus cycle: address latch and decode

   wire [15:0] full_addr = {addr_hi, addr_lo};
   wire        rd_act    = ~sy[S_RD_B];
   wire        wr_act    = ~sy[S_WR_B];

   // range check used for the rf and phone modem windows of the map; ram uses its top bound only
   function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                     input logic [15:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   // shared io slot from a13..a11, zero when not an io address
   function automatic logic [2:0] io_slot(input logic [15:0] a);
      io_slot = (a[15:14] == 2'b10 && a[10:0] == 11'h0) ? a[13:11] : 3'h0;
   endfunction

   // low address byte held for the rest of the cycle
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         addr_lo <= 8'h0;
      end else if (ale_rise) begin
         addr_lo <= port0_in;
      end
   end

   // chip enables, registered from the filtered strobes
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         prog_mem_sel   <= 1'b0;
         ram_ce         <= 1'b0;
         rf_modem_ce    <= 1'b0;
         phone_modem_ce <= 1'b0;
      end else begin
         // code fetch only while the store strobe is low
         prog_mem_sel   <= ~sy[S_PROGRAM_STORE_STROBE_B];
         // data space windows, gated by a read or a write
         ram_ce         <= (rd_act | wr_act) & (full_addr <= RAM_LAST);
         rf_modem_ce    <= (rd_act | wr_act) & in_range(full_addr, RF_FIRST, RF_LAST);
         phone_modem_ce <= (rd_act | wr_act) & in_range(full_addr, PH_FIRST, PH_LAST);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // synchronous receive path with two-entry buffer

   logic [7:0] rx_shift;          // incoming bits
   logic [2:0] rx_bits;           // bits held in rx_shift
   logic [7:0] rx_hold;           // complete byte waiting for the buffer
   logic       in_valid;          // filling side valid
   logic       in_ready;          // filling side ready
   logic [7:0] buf_mem [0:1];     // buffer storage
   logic       buf_wp;            // write index
   logic       buf_rp;            // read index
   logic [1:0] buf_cnt;           // entries held
   logic       out_valid;         // draining side valid
   logic       out_ready;         // draining side ready: cpu reads the modem
   wire        ph_read = rd_fall & in_range(full_addr, PH_FIRST, PH_LAST);

   assign in_ready  = (buf_cnt != 2'h2);
   assign out_valid = (buf_cnt != 2'h0);
   assign out_ready = ph_read;

   // bits shifted in on the receive clock; a full buffer stalls the hold
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_shift             <= 8'h0;
         rx_bits              <= 3'h0;
         rx_hold              <= 8'h0;
         in_valid             <= 1'b0;
         sync_receive_overrun <= 1'b0;
      end else if (sys_reset) begin
         rx_bits  <= 3'h0;
         in_valid <= 1'b0;
      end else begin
         if (rxclk_rise) begin
            rx_shift <= {rx_shift[6:0], sy[S_RXD]};
            rx_bits  <= rx_bits + 3'h1;
         end
         if (rxclk_rise && rx_bits == BIT_LAST) begin
            // a stalled byte still waiting means this one is lost
            sync_receive_overrun <= in_valid & ~in_ready;
            if (!(in_valid && !in_ready)) begin
               rx_hold  <= {rx_shift[6:0], sy[S_RXD]};
               in_valid <= 1'b1;
            end
         end else if (in_valid && in_ready) begin
            in_valid <= 1'b0;
         end
      end
   end

   // buffer pointers and storage
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         buf_wp     <= 1'b0;
         buf_rp     <= 1'b0;
         buf_cnt    <= 2'h0;
         buf_mem[0] <= 8'h0;
         buf_mem[1] <= 8'h0;
      end else begin
         if (in_valid && in_ready) begin
            buf_mem[buf_wp] <= rx_hold;
            buf_wp          <= ~buf_wp;
         end
         if (out_valid && out_ready) begin
            buf_rp <= ~buf_rp;
         end
         buf_cnt <= buf_cnt + 2'((in_valid && in_ready) ? 1 : 0)
                            - 2'((out_valid && out_ready) ? 1 : 0);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // synchronous transmit path

   logic [7:0] tx_shift;          // byte being sent, msb first
   logic [2:0] tx_bits;           // bits sent of current byte
   logic       tx_busy;           // byte loaded and not finished
   wire        ph_write = wr_rise & in_range(full_addr, PH_FIRST, PH_LAST);

   // written byte latched, then shifted out on the transmit clock
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_shift                 <= 8'h0;
         tx_bits                  <= 3'h0;
         tx_busy                  <= 1'b0;
         sync_transmit_serial_out <= 1'b1;
      end else if (ph_write) begin
         tx_shift <= port0_in;
         tx_bits  <= 3'h0;
         tx_busy  <= 1'b1;
      end else if (tx_busy && txclk_fall) begin
         sync_transmit_serial_out <= tx_shift[7];
         tx_shift                 <= {tx_shift[6:0], 1'b0};
         tx_bits                  <= tx_bits + 3'h1;
         tx_busy                  <= (tx_bits != BIT_LAST);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data, switches and output latches

   logic [7:0] ind_latch;         // indicator latch
   logic [7:0] dp_latch;          // data present latch
   logic [7:0] tone_latch;        // tone latch

   // switch banks on reads; open switch reads as one via pull-ups
   // transceiver faces the cpu during switch and phone modem reads
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         port0_out <= 8'h0;
         port0_oe  <= 1'b0;
      end else if (rd_act) begin
         // read strobe selects the buffers at the shared addresses
         if (io_slot(full_addr) == SLOT_A800) begin
            port0_out <= switch_two & SW_PULLUP;
            port0_oe  <= 1'b1;
         end else if (io_slot(full_addr) == SLOT_B000) begin
            port0_out <= switch_one & SW_PULLUP;
            port0_oe  <= 1'b1;
         end else if (io_slot(full_addr) == SLOT_B800) begin
            port0_out <= switch_three & SW_PULLUP;
            port0_oe  <= 1'b1;
         end else if (in_range(full_addr, PH_FIRST, PH_LAST)) begin
            if (rd_fall) begin
               port0_out <= buf_mem[buf_rp];
            end
            port0_oe <= 1'b1;
         end else begin
            port0_oe <= 1'b0;
         end
      end else begin
         port0_oe <= 1'b0;
      end
   end

   // latch write decode from a13..a11 on the write strobe
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ind_latch  <= 8'h0;
         dp_latch   <= 8'h0;
         tone_latch <= 8'h0;
      end else if (sys_reset) begin
         ind_latch  <= 8'h0;
         dp_latch   <= 8'h0;
         tone_latch <= 8'h0;
      end else if (wr_rise) begin
         if (io_slot(full_addr) == SLOT_A800) begin
            ind_latch <= port0_in;
         end else if (io_slot(full_addr) == SLOT_B000) begin
            dp_latch <= port0_in;
         end else if (io_slot(full_addr) == SLOT_B800) begin
            tone_latch <= port0_in;
         end
      end
   end

   // seven indicators straight from the latch
   assign indicators       = ind_latch[6:0];
   assign data_present_out = dp_latch[DATA_PRESENT_BIT];
   assign tone_code_bit    = tone_latch[TONE_BIT];

   // input port sampled freely, three-flop synchronised
   logic [7:0] inp_a, inp_b, inp_c;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         inp_a          <= 8'h0;
         inp_b          <= 8'h0;
         inp_c          <= 8'h0;
         cpu_input_port <= 8'h0;
      end else begin
         inp_a <= ext_inputs;
         inp_b <= inp_a;
         inp_c <= inp_b;
         if (inp_b == inp_c) begin
            cpu_input_port <= inp_c;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // asynchronous channel routing

   tcg_route_t route;             // current destination
   // flashing wins, then site selects, then backup link
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         route <= RT_BACKUP;
      end else if (sy[S_FVPP]) begin
         route <= RT_FLASH;
      end else if (sy[S_SEL1] && (ind_latch[IND_LINE_TWO] || sy[S_JMP])) begin
         route <= RT_SITE1;
      end else if (sy[S_SEL2] && (ind_latch[IND_LINE_FIVE] || sy[S_JMP])) begin
         route <= RT_SITE2;
      end else begin
         route <= RT_BACKUP;
      end
   end

   // one pair, half duplex by use; unselected lines idle high
   always_comb begin
      backup_serial_link_tx = (route == RT_BACKUP) ? cpu_txd : 1'b1;
      flash_tx              = (route == RT_FLASH)  ? cpu_txd : 1'b1;
      site_one_tx           = (route == RT_SITE1)  ? cpu_txd : 1'b1;
      site_two_tx           = (route == RT_SITE2)  ? cpu_txd : 1'b1;
      case (route)
         RT_FLASH: cpu_rxd = flash_rx;
         RT_SITE1: cpu_rxd = site_one_rx;
         RT_SITE2: cpu_rxd = site_two_rx;
         default:  cpu_rxd = backup_serial_link_rx;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   sequence flash_edge_s;
      (rst_st == RST_IDLE) && flash_chg;
   endsequence

   sequence pulse_seen_s;
      ##2 sys_reset;
   endsequence

   a_flash_reset_pulse: assert property (@(posedge core_clk) disable iff (!rst_b)
      flash_edge_s |-> pulse_seen_s) else $error("no reset after flash change");

   a_wdog_expiry_reset: assert property (@(posedge core_clk) disable iff (!rst_b)
      wdog_fire |-> ##2 sys_reset) else $error("watchdog expiry did not reset");

   a_modem_reset_path: assert property (@(posedge core_clk) disable iff (!rst_b)
      sy[S_MRST] |=> (cpu_reset && phone_modem_reset)) else $error("modem reset not passed");

   a_latch_cleared: assert property (@(posedge core_clk) disable iff (!rst_b)
      sys_reset |=> (ind_latch == 8'h0)) else $error("latch kept value in reset");

   a_addr_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
      ale_rise |=> (addr_lo == $past(port0_in))) else $error("low address not latched");

   a_write_no_read: assert property (@(posedge core_clk) disable iff (!rst_b)
      (wr_act && !rd_act) |=> !port0_oe) else $error("bus driven during write");

   a_buf_pop_data: assert property (@(posedge core_clk) disable iff (!rst_b)
      (out_valid && out_ready) |=> (port0_out == $past(buf_mem[buf_rp])))
      else $error("popped byte not on bus");

   a_flash_route: assert property (@(posedge core_clk) disable iff (!rst_b)
      sy[S_FVPP] |=> (route == RT_FLASH)) else $error("flash not routed");

   a_tone_follow: assert property (@(posedge core_clk) disable iff (!rst_b)
      (wr_rise && io_slot(full_addr) == SLOT_B800 && !sys_reset)
         |=> (tone_code_bit == $past(port0_in[TONE_BIT]))) else $error("tone bit not stored");

endmodule

// File: logic/tcg_pkg.sv
// constants, address map and state codes for the trunking card glue
package tcg_pkg;
   // clock rate of core_clk
   localparam int          CLK_MHZ          = 200;
   // watchdog service interval limit in milliseconds
   localparam int          WDOG_TIMEOUT_MS  = 2000;
   localparam longint      WDOG_CYCLES_L    = longint'(WDOG_TIMEOUT_MS) * 1000 * CLK_MHZ;
   // width of the generated reset pulse in microseconds
   localparam int          RST_PULSE_US     = 10;
   localparam int          RST_PULSE_CYC    = RST_PULSE_US * CLK_MHZ;
   localparam logic [15:0] RST_PULSE_LAST   = 16'(RST_PULSE_CYC - 1);
   // external data space map
   localparam logic [15:0] RAM_LAST         = 16'h1fff;
   localparam logic [15:0] RF_FIRST         = 16'ha170;
   localparam logic [15:0] RF_LAST          = 16'ha172;
   localparam logic [15:0] PH_FIRST         = 16'ha0f0;
   localparam logic [15:0] PH_LAST          = 16'ha0f2;
   // shared switch buffer / output latch addresses
   localparam logic [15:0] SW2_LATCH_ADDR   = 16'ha800;
   localparam logic [15:0] SW1_LATCH_ADDR   = 16'hb000;
   localparam logic [15:0] SW3_LATCH_ADDR   = 16'hb800;
   // codes of address lines a13..a11 for the shared io slots
   localparam logic [2:0]  SLOT_A800        = 3'h5;
   localparam logic [2:0]  SLOT_B000        = 3'h6;
   localparam logic [2:0]  SLOT_B800        = 3'h7;
   // bit positions inside the output latches
   localparam int          IND_LINE_TWO     = 2;
   localparam int          IND_LINE_FIVE    = 5;
   localparam int          DATA_PRESENT_BIT = 0;
   localparam int          TONE_BIT         = 0;
   // width of the asynchronous input vector and its slots
   localparam int          NSYNC            = 13;
   localparam int          S_ALE = 0, S_PROGRAM_STORE_STROBE_B = 1, S_RD_B = 2, S_WR_B = 3, S_WDOG = 4;
   localparam int          S_MRST = 5, S_FVPP = 6, S_RXCLK = 7, S_RXD = 8, S_TXCLK = 9;
   localparam int          S_SEL1 = 10, S_SEL2 = 11, S_JMP = 12;
   // idle level of each synchronised pin: the three strobes rest high
   localparam logic [NSYNC-1:0] SYNC_IDLE = 13'h000e;
   // byte length of the synchronous modem path
   localparam logic [2:0]  BIT_LAST         = 3'h7;
   localparam logic [7:0]  SW_PULLUP        = 8'hff;
   // reset generator states
   typedef enum logic [1:0] {
      RST_IDLE  = 2'b01,
      RST_PULSE = 2'b10
   } tcg_rst_state_t;
   // destination of the asynchronous channel
   typedef enum logic [3:0] {
      RT_BACKUP = 4'b0001,
      RT_FLASH  = 4'b0010,
      RT_SITE1  = 4'b0100,
      RT_SITE2  = 4'b1000
   } tcg_route_t;
endpackage

// File: sim/tb_tcg_glue.sv
// self-checking bench for the trunking card glue
`timescale 1ns/10ps
module tb_tcg_glue;
   import tcg_pkg::*;
   logic core_clk = 0, rst_b = 0, reference_clock = 0, ale = 0, program_store_strobe_b = 1, rd_b = 1, wr_b = 1;
   logic watchdog_service = 0, modem_reset_in = 0, flash_vpp = 0, site_link_select_one = 0, feed = 1;
   logic site_link_select_two = 0, jumper_route_select = 0, cpu_txd = 1, backup_serial_link_rx = 1, flash_rx = 1;
   logic site_one_rx = 1, site_two_rx = 1, sync_transmit_clock = 0, oe_s;
   logic [7:0] port0_in = 8'h00, addr_hi = 8'h00, ext_inputs = 8'h3c, rd, lo_s;
   logic [7:0] switch_one = 8'ha5, switch_two = 8'h5a, switch_three = 8'hc3;
   logic modem_clk_out, cpu_clk_out, port0_oe, prog_mem_sel, ram_ce, rf_modem_ce, phone_modem_ce;
   logic flash_mode_active, cpu_reset, phone_modem_reset, data_present_out, tone_code_bit, cpu_rxd;
   logic backup_serial_link_tx, flash_tx, site_one_tx, site_two_tx, sync_receive_clock, sync_receive_serial_in;
   logic sync_transmit_serial_out, sync_receive_overrun;
   logic [7:0] port0_out, addr_lo, cpu_input_port;
   logic [6:0] indicators;
   logic [2:0] ce_s;
   int n_mismatch = 0, samples_checked = 0;
   tcg_glue #(.WDOG_CYCLES(1000)) u_tcg_glue (.*);
   tcg_sync_src u_tcg_sync_src (.*);
   always #2.5 core_clk = ~core_clk;
   // software services well inside the interval
   always begin
      repeat (200) @(negedge core_clk);
      if (feed) watchdog_service = ~watchdog_service;
   end
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // one bus cycle; ale held 4 cycles, read and write strobes held 8, to clear the input filter
   task automatic bus(input logic [15:0] a, input logic [7:0] d, input logic wr);
      {addr_hi, port0_in} = a;
      ale = 1'b1;
      wait_n(4);
      ale = 1'b0;
      wait_n(4);
      port0_in = d;
      if (wr) wr_b = 1'b0;
      else rd_b = 1'b0;
      wait_n(8);
      rd = port0_out;
      oe_s = port0_oe;
      lo_s = addr_lo;
      ce_s = {ram_ce, rf_modem_ce, phone_modem_ce};
      rd_b = 1'b1;
      wr_b = 1'b1;
      wait_n(8);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #200us;
      n_mismatch++;
      wrap_up();
   end
   initial begin
      wait_n(3);
      chk("rst", 8'(cpu_reset), 8'h01); // held in reset
      rst_b = 1'b1;
      wait_n(8);
      reference_clock = 1'b1;
      #1 chk("clk", 8'({cpu_clk_out, modem_clk_out}), 8'h03); // clock copies
      bus(16'ha800, 8'h55, 1'b1);
      bus(16'hb000, 8'h01, 1'b1);
      bus(16'hb800, 8'h01, 1'b1);
      chk("ind", 8'(indicators), 8'h55); // leds
      chk("dp_tone", 8'({data_present_out, tone_code_bit}), 8'h03); // latch bits
      bus(16'ha800, 8'h00, 1'b0);
      chk("sw2", rd, switch_two); // switch read
      bus(16'hb000, 8'h00, 1'b0);
      chk("sw1", rd, switch_one); // switch read
      bus(16'hb800, 8'h00, 1'b0);
      chk("sw3", rd, switch_three); // switch read
      bus(16'h1fff, 8'h00, 1'b0);
      chk("ram", {lo_s[3:0], 1'b0, ce_s}, 8'hf4); // ram top
      chk("oe", 8'(oe_s), 8'h00); // not switch or modem
      bus(16'ha171, 8'h00, 1'b0);
      chk("rf", 8'(ce_s), 8'h02); // rf modem
      chk("port", cpu_input_port, 8'h3c); // input port
      for (int i = 0; i < 4; i++) u_tcg_sync_src.send(8'h96 ^ 8'(i));
      wait_n(8);
      chk("ovr", 8'(sync_receive_overrun), 8'h01); // fourth byte lost, buffer and hold full
      bus(16'ha0f0, 8'h00, 1'b0);
      chk("ph", rd, 8'h96); // received byte
      chk("ph_ce", 8'(ce_s), 8'h01); // phone modem
      bus(16'ha0f2, 8'h00, 1'b0);
      chk("ph2", rd, 8'h97); // second byte kept in order
      bus(16'ha0f1, 8'h7f, 1'b1);
      sync_transmit_clock = 1'b1;
      wait_n(6);
      sync_transmit_clock = 1'b0;
      wait_n(6);
      chk("tx", 8'(sync_transmit_serial_out), 8'h00); // msb leaves first
      site_link_select_one = 1'b1;
      cpu_txd = 1'b0;
      wait_n(8);
      chk("site1", 8'({site_one_tx, backup_serial_link_tx}), 8'h01); // site one
      site_link_select_one = 1'b0;
      program_store_strobe_b = 1'b0;
      wait_n(8);
      chk("bsl_program_store_strobe", 8'({backup_serial_link_tx, prog_mem_sel}), 8'h01); // backup, fetch
      program_store_strobe_b = 1'b1;
      cpu_txd = 1'b1;
      modem_reset_in = 1'b1;
      wait_n(8);
      chk("mrst", {indicators, 1'b0} | 8'({cpu_reset, phone_modem_reset}), 8'h03); // all reset
      modem_reset_in = 1'b0;
      flash_vpp = 1'b1;
      wait_n(8);
      chk("fl_in", 8'(cpu_reset), 8'h01); // entry pulse
      wait_n(2100);
      flash_rx = 1'b0;
      cpu_txd = 1'b0;
      #1 chk("fl", 8'({flash_mode_active, cpu_rxd, flash_tx}), 8'h04); // flash route
      flash_vpp = 1'b0;
      wait_n(8);
      chk("fl_out", 8'(cpu_reset), 8'h01); // exit pulse
      wait_n(2100);
      chk("fl_end", 8'({flash_mode_active, cpu_reset}), 8'h00); // fed, running
      feed = 1'b0;
      wait_n(500);
      chk("wd_early", 8'(cpu_reset), 8'h00); // not yet due
      wait_n(600);
      chk("wd", 8'(cpu_reset), 8'h01); // timeout reset
      wrap_up();
   end
endmodule

// File: sim/tcg_sync_src.sv
// partner model: far-end source of the phone modem receive line
`timescale 1ns/10ps
module tcg_sync_src (
   input  wire logic core_clk,
   output logic      sync_receive_clock,
   output logic      sync_receive_serial_in
);
   // clock stands still low between frames
   initial begin
      sync_receive_clock = 1'b0;
      sync_receive_serial_in = 1'b1;
   end
   task automatic send(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         sync_receive_serial_in = b[i];
         repeat (4) @(negedge core_clk);
         sync_receive_clock = 1'b1;
         repeat (4) @(negedge core_clk);
         sync_receive_clock = 1'b0;
      end
      // released line shows the inverse, never a stale bit
      sync_receive_serial_in = ~b[0];
      // gap before the next frame, so two changes never share a step
      repeat (4) @(negedge core_clk);
   endtask
endmodule
